// ==== logic/gdfsb_consts.svh ====
`ifndef GDFSB_CONSTS_SVH
`define GDFSB_CONSTS_SVH

`define GDF_ADDR_W         7
`define GDF_DATA_W         32
`define GDF_FLAG_W         15
`define GDF_ADDR_FLAGS     7'h01
`define GDF_ADDR_READBACK  7'h04

`define GDF_B_RESET        0
`define GDF_B_OTPW         1
`define GDF_B_OT           2
`define GDF_B_PUMP_UV      3
`define GDF_B_SC_U         4
`define GDF_B_S2G_U        5
`define GDF_B_S2VS_U       6
`define GDF_PHASE_STRIDE   4
`define GDF_PHASES         3

`define GDF_FLAGS_RST      15'h0001
`define GDF_STATUS_MASK    15'h777C
`define GDF_DISABLE_MASK   15'h6664
`define GDF_CYCLE_CLR_MASK 15'h7FFC
`define GDF_DRV_EN_RST     1'b1
`define GDF_VERSION_RST    8'hA5

`define GDF_IO_B_PINS      0
`define GDF_IO_B_DRV_EN    6
`define GDF_IO_B_ZERO      7
`define GDF_IO_B_OTPW      8
`define GDF_IO_B_OT136     9
`define GDF_IO_B_OT143     10
`define GDF_IO_B_VER       24
`define GDF_IO_PINS_W      6
`define GDF_IO_VER_W       8

`endif

// ==== logic/gdfsb_pkg.sv ====
`default_nettype none

package gdfsb_pkg;

  typedef struct packed {
    logic phase_w_high_in;
    logic phase_w_low_in;
    logic phase_v_high_in;
    logic phase_v_low_in;
    logic phase_u_high_in;
    logic phase_u_low_in;
  } gdfsb_pins_t;

  typedef struct packed {
    logic       pump_uv;
    logic [2:0] short_cnt;
    logic [2:0] s2g;
    logic [2:0] s2vs;
    logic       otpw;
    logic       ot;
    logic       temp_136c_state;
    logic       temp_143c_state;
  } gdfsb_evt_t;

endpackage

`default_nettype wire

// ==== logic/gdfsb_flag_cell.sv ====
`timescale 1ns/100ps
`default_nettype none

// one sticky status bit; a set in the clearing cycle wins
module gdfsb_flag_cell #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_flag
);

  logic flag_ff;
  logic nxt_flag;

  always_comb begin
    nxt_flag = flag_ff;
    if (i_clr) begin
      nxt_flag = 1'b0;
    end
    if (i_set) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_ff <= RST_VAL;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign o_flag = flag_ff;

endmodule

`default_nettype wire

// ==== logic/gdfsb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "gdfsb_consts.svh"

module gdfsb_top #(
  parameter logic [7:0] VERSION = `GDF_VERSION_RST  // arbitrary value
) (
  input  wire logic                     I_CLK_SYS,
  input  wire logic                     I_RST,
  input  wire logic [`GDF_ADDR_W-1:0]   I_ADDR,
  input  wire logic                     I_WR,
  input  wire logic [`GDF_DATA_W-1:0]   I_WDATA,
  input  wire logic                     I_RD,
  output logic      [`GDF_DATA_W-1:0]   O_RDATA,
  input  wire gdfsb_pkg::gdfsb_pins_t   I_PINS,
  input  wire logic                     I_DRV_EN,
  input  wire gdfsb_pkg::gdfsb_evt_t    I_EVT,
  output logic                          O_STATUS,
  output logic                          O_DRV_DISABLE
);

  logic [`GDF_FLAG_W-1:0] flags;
  logic [`GDF_FLAG_W-1:0] flag_set;
  logic [`GDF_FLAG_W-1:0] flag_clr;
  logic                   drv_en_prev_ff;
  logic                   nxt_drv_en_prev;
  logic                   drv_en_rise;
  logic                   flags_wr;
  logic [`GDF_DATA_W-1:0] rdata_ff;
  logic [`GDF_DATA_W-1:0] nxt_rdata;

  // enable pin edge detector for the bulk clear
  always_comb begin
    nxt_drv_en_prev = I_DRV_EN;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      drv_en_prev_ff <= `GDF_DRV_EN_RST;
    end else begin
      drv_en_prev_ff <= nxt_drv_en_prev;
    end
  end

  assign drv_en_rise = I_DRV_EN && !drv_en_prev_ff;
  assign flags_wr    = I_WR && (I_ADDR == `GDF_ADDR_FLAGS);

  // event to flag mapping
  always_comb begin
    flag_set = '0;
    flag_set[`GDF_B_OTPW]  = I_EVT.otpw;
    flag_set[`GDF_B_OT]    = I_EVT.ot;
    flag_set[`GDF_B_PUMP_UV] = I_EVT.pump_uv;
    for (int p = 0; p < `GDF_PHASES; p++) begin
      flag_set[`GDF_B_SC_U   + `GDF_PHASE_STRIDE*p] = I_EVT.short_cnt[p];
      flag_set[`GDF_B_S2G_U  + `GDF_PHASE_STRIDE*p] = I_EVT.s2g[p];
      flag_set[`GDF_B_S2VS_U + `GDF_PHASE_STRIDE*p] = I_EVT.s2vs[p];
    end
  end

  // write-one clear, plus bulk clear on an enable low-high cycle
  always_comb begin
    flag_clr = '0;
    if (flags_wr) begin
      flag_clr = I_WDATA[`GDF_FLAG_W-1:0];
      // reset indication clears only with the enable pin high
      flag_clr[`GDF_B_RESET] = I_WDATA[`GDF_B_RESET] && I_DRV_EN;
    end
    if (drv_en_rise) begin
      flag_clr = flag_clr | `GDF_CYCLE_CLR_MASK;
    end
  end

  for (genvar b = 0; b < `GDF_FLAG_W; b++) begin : g_flag
    localparam logic [`GDF_FLAG_W-1:0] RST_VEC = `GDF_FLAGS_RST;
    gdfsb_flag_cell #(
      .RST_VAL (RST_VEC[b])
    ) u_cell (
      .i_clk   (I_CLK_SYS),
      .i_rst   (I_RST),
      .i_set   (flag_set[b]),
      .i_clr   (flag_clr[b]),
      .o_flag  (flags[b])
    );
  end

  assign O_STATUS      = |(flags & `GDF_STATUS_MASK);
  // for undervoltage only the live input holds the driver off; the latched flag is not in the disable mask
  assign O_DRV_DISABLE = I_EVT.pump_uv || |(flags & `GDF_DISABLE_MASK);

  // registered read data
  always_comb begin
    nxt_rdata = rdata_ff;
    if (I_RD) begin
      nxt_rdata = '0;
      if (I_ADDR == `GDF_ADDR_FLAGS) begin
        nxt_rdata[`GDF_FLAG_W-1:0] = flags;
      end else if (I_ADDR == `GDF_ADDR_READBACK) begin
        nxt_rdata[`GDF_IO_B_PINS +: `GDF_IO_PINS_W] = I_PINS;
        nxt_rdata[`GDF_IO_B_DRV_EN]    = I_DRV_EN;
        nxt_rdata[`GDF_IO_B_ZERO]      = 1'b0;
        nxt_rdata[`GDF_IO_B_OTPW]      = I_EVT.otpw;
        nxt_rdata[`GDF_IO_B_OT136]     = I_EVT.temp_136c_state;
        nxt_rdata[`GDF_IO_B_OT143]     = I_EVT.temp_143c_state;
        nxt_rdata[`GDF_IO_B_VER +: `GDF_IO_VER_W] = VERSION;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign O_RDATA = rdata_ff;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  sequence s_enable_cycle;
    !I_DRV_EN ##1 I_DRV_EN;
  endsequence

  sequence s_readback_read;
    I_RD && (I_ADDR == `GDF_ADDR_READBACK);
  endsequence

  property p_uv_disable;
    I_EVT.pump_uv |-> O_DRV_DISABLE ##1 (flags[`GDF_B_PUMP_UV] && O_STATUS);
  endproperty
  a_uv_disable: assert property (p_uv_disable) else $error("uv not disabling");

  property p_uv_bit;
    I_EVT.pump_uv |=> flags[3];
  endproperty
  a_uv_bit: assert property (p_uv_bit) else $error("uv flag not at bit 3");

  property p_short_cnt;
    I_EVT.short_cnt[1] |=> flags[8] && O_STATUS;
  endproperty
  a_short_cnt: assert property (p_short_cnt) else $error("short count flag v");

  property p_ground_short;
    I_EVT.s2g[2] |=> flags[13] && O_DRV_DISABLE;
  endproperty
  a_ground_short: assert property (p_ground_short) else $error("ground short w");

  property p_supply_short;
    I_EVT.s2vs[0] |=> flags[6] && O_DRV_DISABLE;
  endproperty
  a_supply_short: assert property (p_supply_short) else $error("supply short u");

  property p_status_or;
    (flags & `GDF_STATUS_MASK) == '0 |-> !O_STATUS;
  endproperty
  a_status_or: assert property (p_status_or) else $error("status without flag");

  property p_readback_pins;
    s_readback_read |=> O_RDATA[6:0] == $past({I_DRV_EN, I_PINS});
  endproperty
  a_readback_pins: assert property (p_readback_pins) else $error("pin readback");

  property p_readback_temp;
    s_readback_read |=> !O_RDATA[7] && O_RDATA[10:8] ==
      $past({I_EVT.temp_143c_state, I_EVT.temp_136c_state, I_EVT.otpw});
  endproperty
  a_readback_temp: assert property (p_readback_temp) else $error("temp readback");

  // bit 0 kept out of the write so the reset indication must stay put
  property p_w1c;
    flags_wr && I_WDATA[9] && !I_WDATA[0] && !I_EVT.s2g[1] && !drv_en_rise |=>
      !flags[9] ##0 flags[0] == $past(flags[0]);
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one clear failed");

  property p_set_wins;
    flags_wr && I_WDATA[5] && I_EVT.s2g[0] |=> flags[5];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

  property p_cycle_clear;
    s_enable_cycle ##0 (I_EVT == '0 && !flags_wr) |=>
      (flags & `GDF_CYCLE_CLR_MASK) == '0 && flags[1:0] == $past(flags[1:0]);
  endproperty
  a_cycle_clear: assert property (p_cycle_clear) else $error("enable cycle clear");

endmodule

`default_nettype wire

// ==== tb/gdfsb_host.sv ====
`timescale 1ns/100ps
`default_nettype none

// controller side of the register bus; drives just after an edge
module gdfsb_host (
  input  wire logic        i_clk,
  output logic [6:0]       o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic [31:0]      o_wdata,
  input  wire logic [31:0] i_rdata
);
  logic [31:0] q;

  initial begin
    o_addr = 7'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 32'h0;
  end

  // write one to clear is issued through this same cycle
  task xfer(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_wdata <= ~d;
    #1 q = i_rdata;
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_gdfsb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_gdfsb_top;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic [6:0]             addr;
  logic                   wr;
  logic                   rd_s;
  logic [31:0]            wdata;
  logic [31:0]            rdata;
  gdfsb_pkg::gdfsb_pins_t pins = 6'h3F;
  logic                   drv_en = 1'b1;
  gdfsb_pkg::gdfsb_evt_t  evt = '0;
  gdfsb_pkg::gdfsb_evt_t  e;
  logic                   status;
  logic                   dis;
  int                     n_mismatch = 0;
  int                     n_tests = 0;
  int                     cyc = 0;
  int                     b;

  always #10 clk = ~clk;

  gdfsb_top #(.VERSION(8'h3C)) DUT ( // arbitrary value
    .I_CLK_SYS(clk), .I_RST(rst), .I_ADDR(addr), .I_WR(wr), .I_WDATA(wdata),
    .I_RD(rd_s), .O_RDATA(rdata), .I_PINS(pins), .I_DRV_EN(drv_en),
    .I_EVT(evt), .O_STATUS(status), .O_DRV_DISABLE(dis));

  gdfsb_host host (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd_s),
    .o_wdata(wdata), .i_rdata(rdata));

  task give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_pins(input logic exp_status, input logic exp_dis);
    n_tests++;
    if ({status, dis} !== {exp_status, exp_dis}) begin
      n_mismatch++;
      $display("mismatch at %0t: status/disable %b expected %b", $time,
        {status, dis}, {exp_status, exp_dis});
    end
  endtask

  task rd(input logic [6:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0);
    chk(host.q, exp);
  endtask

  task pulse(input gdfsb_pkg::gdfsb_evt_t ev);
    @(posedge clk);
    evt <= ev;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(7'h01, 32'h1);
    chk_pins(1'b0, 1'b0);
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 3; k++) begin
        e = '0;
        case (k)
          0: e.short_cnt[p] = 1'b1;
          1: e.s2g[p] = 1'b1;
          default: e.s2vs[p] = 1'b1;
        endcase
        b = 4 + 4 * p + k;
        pulse(e);
        repeat (3) @(posedge clk);
        #1 chk_pins(1'b1, 1'(k != 0));
        rd(7'h01, 32'h1 | (32'h1 << b));
        @(posedge clk);
        pins <= '0;
        host.xfer(1'b1, 7'h01, 32'h1 << b);
        chk_pins(1'b0, 1'b0);
        @(posedge clk);
        pins <= 6'h3F;
      end
    end
    e = '0;
    e.pump_uv = 1'b1;
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    #1 chk_pins(1'b1, 1'b1);
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
    #1 chk_pins(1'b1, 1'b0);
    e = '0;
    e.otpw = 1'b1;
    e.s2g[1] = 1'b1;
    pulse(e);
    rd(7'h01, 32'h20B);
    host.xfer(1'b1, 7'h05, 32'h7FFF);
    rd(7'h01, 32'h20B);
    rd(7'h02, 32'h0);
    @(posedge clk);
    drv_en <= 1'b0;
    @(posedge clk);
    drv_en <= 1'b1;
    @(posedge clk);
    #1 chk_pins(1'b0, 1'b0);
    rd(7'h01, 32'h3);
    // ground short held high across its own clearing write: the set must win
    e = '0;
    e.s2g[0] = 1'b1;
    @(posedge clk);
    evt <= e;
    host.xfer(1'b1, 7'h01, 32'h20);
    @(posedge clk);
    evt <= '0;
    rd(7'h01, 32'h23);
    chk_pins(1'b1, 1'b1);
    host.xfer(1'b1, 7'h01, 32'h23);
    rd(7'h01, 32'h0);
    chk_pins(1'b0, 1'b0);
    e = '0;
    e.otpw = 1'b1;
    e.temp_136c_state = 1'b1;
    e.temp_143c_state = 1'b1;
    @(posedge clk);
    pins <= 6'h2A;
    evt <= e;
    rd(7'h04, {8'h3C, 13'h0, 3'b111, 2'b01, 6'h2A});
    @(posedge clk);
    evt <= '0;
    pins <= 6'h15;
    drv_en <= 1'b0;
    rd(7'h04, {8'h3C, 24'h15});
    // mid-run reset with the enable pin low, then the reset indication clear
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(7'h01, 32'h1);
    chk_pins(1'b0, 1'b0);
    host.xfer(1'b1, 7'h01, 32'h1);
    rd(7'h01, 32'h1);
    @(posedge clk);
    drv_en <= 1'b1;
    host.xfer(1'b1, 7'h01, 32'h1);
    rd(7'h01, 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
